// ==== design/rgm_pkg.sv ====
// Shared constants and types of the receive gain block
package rgm_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [7:0]  IDX_FIRST_GAIN   = 8'h0c;
   localparam logic [7:0]  IDX_LATER_GAIN   = 8'h0d;
   localparam logic [7:0]  IDX_MASK_TIME    = 8'h0e;
   localparam logic [7:0]  IDX_COMMAND      = 8'h20;
   localparam logic [7:0]  IDX_MODE         = 8'h21;
   localparam logic [7:0]  IDX_STATUS       = 8'h22;
   localparam int          ADDR_W           = 12;
   // Reset values
   localparam logic [7:0]  RST_FIRST_GAIN   = 8'hd8;
   localparam logic [7:0]  RST_LATER_GAIN   = 8'h00;
   localparam logic [7:0]  RST_MASK_TIME    = 8'h08;
   localparam logic [7:0]  RST_MODE         = 8'h04;
   // First stage gain register fields
   localparam int          F1_AM_LSB        = 5;
   localparam int          F1_PM_LSB        = 2;
   localparam int          F1_CLIP          = 1;
   localparam int          F1_PRESET        = 0;
   // Later stage gain register fields
   localparam int          F2_AM_LSB        = 4;
   localparam int          F2_PM_LSB        = 0;
   // Command register bits (write one to fire)
   localparam int          CMD_SET_DEFAULT  = 0;
   localparam int          CMD_GAIN_RESET   = 1;
   // Mode register bits
   localparam int          MODE_BITRATE_DET = 0;
   localparam int          MODE_TYPEA_106   = 1;
   localparam int          MODE_DYN_SQUELCH = 2;
   // First stage code meaning
   localparam logic [2:0]  G1_FULL          = 3'h0;
   localparam logic [2:0]  G1_BOOST         = 3'h7;
   // Later stage code limits
   localparam logic [3:0]  G2_WIN_MAX       = 4'h4;
   localparam logic [3:0]  G2_CODE_MAX      = 4'ha;
   localparam logic [2:0]  G2_PRESET_CUT    = 3'h2;
   // Mask timer figures in carrier periods; minimum count in steps
   localparam int          MASK_STEP_FC     = 64;
   localparam int          MASK_SLOW_FC     = 512;
   localparam int          FDT_HALF_STEP_FC = 64;
   localparam logic [7:0]  MASK_MIN_STEPS   = 8'h04;
   localparam int          SQUELCH_START_FC = 256;
   // AXI responses
   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;

   // Decoded first stage setting of one channel
   typedef struct packed {
      logic       boost;       // +5.5 dB boost active
      logic [2:0] cut_steps;   // 2.5 dB reduction steps, 0..6
   } rgm_first_s;

   // Decoded later stage setting of one channel
   typedef struct packed {
      logic [2:0] win_steps;   // Digitizer window widening, 3 dB steps
      logic [2:0] cut_steps;   // Second and third stage cut, 3 dB steps
   } rgm_later_s;
endpackage

// ==== design/rgm_mask_timer.sv ====
// Mask receive timer with dynamic squelch window
`timescale 1ns/1ps
`default_nettype none
module rgm_mask_timer (
   input  wire logic       clk_i,            // System clock
   input  wire logic       rst_i,            // Synchronous reset, active high
   input  wire logic       fc_tick_i,        // One pulse per carrier period
   input  wire logic       eot_i,            // End of transmission pulse
   input  wire logic [7:0] count_i,          // Programmed mask count
   input  wire logic       slow_i,           // Bit rate detection mode
   input  wire logic       typea_i,          // Type A 106 kbit/s reception
   input  wire logic       dyn_squelch_i,    // Dynamic squelch enable
   output logic            masked_o,         // Receiver output ignored
   output logic            squelch_o         // Squelch active
);
   localparam int          EW = 17;          // Holds 255 * 512 carrier periods

   logic          busy_reg;                  // Timer running
   logic          busy_next;
   logic [EW-1:0] elapsed_reg;               // Carrier periods since end of Tx
   logic [EW-1:0] elapsed_next;
   logic [EW-1:0] target_reg;                // Carrier periods to mask
   logic [7:0]    eff_count;                 // Count after minimum clamp
   logic [EW-1:0] target_calc;
   logic          expire;

   // Counts 0 to 4 all give the minimum of four steps
   assign eff_count = (count_i < rgm_pkg::MASK_MIN_STEPS) ? rgm_pkg::MASK_MIN_STEPS : count_i;
   // Step size: 64 fc, half frame-delay step for type A, 512 fc when detecting bit rate
   assign target_calc = slow_i ? EW'(32'(eff_count) * rgm_pkg::MASK_SLOW_FC)
                      : typea_i ? EW'(32'(eff_count) * rgm_pkg::FDT_HALF_STEP_FC)
                      : EW'(32'(eff_count) * rgm_pkg::MASK_STEP_FC);
   assign expire = busy_reg && fc_tick_i && (elapsed_reg + EW'(1) >= target_reg);

   // Restart on every end of Tx; release only on expiry
   assign busy_next = eot_i ? 1'b1 : (expire ? 1'b0 : busy_reg);
   assign elapsed_next = eot_i ? '0 : ((busy_reg && fc_tick_i) ? elapsed_reg + EW'(1) : elapsed_reg);

   // Timer state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_reg    <= 1'b0;
         elapsed_reg <= '0;
         target_reg  <= '0;
      end else begin
         busy_reg    <= busy_next;
         elapsed_reg <= elapsed_next;
         if (eot_i) begin
            target_reg <= target_calc;   // Count captured at end of Tx
         end
      end
   end

   assign masked_o  = busy_reg;
   // Squelch from 256 fc after end of Tx until the timer expires
   assign squelch_o = busy_reg && dyn_squelch_i && (elapsed_reg >= EW'(rgm_pkg::SQUELCH_START_FC));
endmodule
`default_nettype wire

// ==== design/rgm_top.sv ====
// Receive gain configuration and mask timer register bank with AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module rgm_top (
   input  wire logic                  CLK_SYS_I,        // 200 MHz system clock
   input  wire logic                  SYS_RST_I,        // Synchronous reset, active high
   // AXI4-Lite write address
   input  wire logic                  S_AXI_AWVALID_I,
   output logic                       S_AXI_AWREADY_O,
   input  wire logic [11:0]           S_AXI_AWADDR_I,
   input  wire logic [2:0]            S_AXI_AWPROT_I,
   // AXI4-Lite write data
   input  wire logic                  S_AXI_WVALID_I,
   output logic                       S_AXI_WREADY_O,
   input  wire logic [31:0]           S_AXI_WDATA_I,
   input  wire logic [3:0]            S_AXI_WSTRB_I,
   // AXI4-Lite write response
   output logic                       S_AXI_BVALID_O,
   input  wire logic                  S_AXI_BREADY_I,
   output logic [1:0]                 S_AXI_BRESP_O,
   // AXI4-Lite read address
   input  wire logic                  S_AXI_ARVALID_I,
   output logic                       S_AXI_ARREADY_O,
   input  wire logic [11:0]           S_AXI_ARADDR_I,
   input  wire logic [2:0]            S_AXI_ARPROT_I,
   // AXI4-Lite read data
   output logic                       S_AXI_RVALID_O,
   input  wire logic                  S_AXI_RREADY_I,
   output logic [31:0]                S_AXI_RDATA_O,
   output logic [1:0]                 S_AXI_RRESP_O,
   // Receive path events, same clock domain
   input  wire logic                  FC_TICK_I,        // One pulse per carrier period
   input  wire logic                  TX_END_I,         // End of transmission pulse
   input  wire logic                  RX_OUT_I,         // Raw receiver output valid
   // Analog and receive path controls
   output rgm_pkg::rgm_first_s        AM_FIRST_GAIN_O,  // Decoded AM first stage
   output rgm_pkg::rgm_first_s        PM_FIRST_GAIN_O,  // Decoded PM first stage
   output logic                       CLIP_EN_O,        // Clip first and second stage
   output rgm_pkg::rgm_later_s        AM_LATER_GAIN_O,  // Loaded AM later stages
   output rgm_pkg::rgm_later_s        PM_LATER_GAIN_O,  // Loaded PM later stages
   output logic                       RX_MASKED_O,      // Receiver output ignored
   output logic                       RX_OUT_O,         // Receiver output after mask
   output logic                       SQUELCH_O         // Squelch active
);
   localparam int                ADDR_W     = rgm_pkg::ADDR_W;
   localparam logic [ADDR_W-1:0] ADDR_FIRST = ADDR_W'({rgm_pkg::IDX_FIRST_GAIN, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_LATER = ADDR_W'({rgm_pkg::IDX_LATER_GAIN, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_MASK  = ADDR_W'({rgm_pkg::IDX_MASK_TIME, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_CMD   = ADDR_W'({rgm_pkg::IDX_COMMAND, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_MODE  = ADDR_W'({rgm_pkg::IDX_MODE, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_STAT  = ADDR_W'({rgm_pkg::IDX_STATUS, 2'b00});

   // First stage code to boost flag and cut steps
   function automatic rgm_pkg::rgm_first_s decode_first(input logic [2:0] code);
      rgm_pkg::rgm_first_s r;
      r.boost     = (code == rgm_pkg::G1_BOOST);
      r.cut_steps = (code == rgm_pkg::G1_BOOST) ? rgm_pkg::G1_FULL : code;
      return r;
   endfunction

   // Later stage code to window and cut steps; unused codes clamp to the top code
   function automatic rgm_pkg::rgm_later_s decode_later(input logic [3:0] code, input logic preset);
      rgm_pkg::rgm_later_s r;
      logic [3:0] c;
      c = (code > rgm_pkg::G2_CODE_MAX) ? rgm_pkg::G2_CODE_MAX : code;
      if (preset) begin
         r.win_steps = rgm_pkg::G2_WIN_MAX[2:0];
         r.cut_steps = rgm_pkg::G2_PRESET_CUT;
      end else if (c <= rgm_pkg::G2_WIN_MAX) begin
         r.win_steps = c[2:0];
         r.cut_steps = 3'h0;
      end else begin
         r.win_steps = rgm_pkg::G2_WIN_MAX[2:0];
         r.cut_steps = 3'(c - rgm_pkg::G2_WIN_MAX);
      end
      return r;
   endfunction

   // Software visible registers
   logic [7:0]           first_gain_reg;      // First stage gains, clip, preset
   logic [7:0]           first_gain_next;
   logic [7:0]           later_gain_reg;      // Later stage gain codes as written
   logic [7:0]           later_gain_next;
   logic [7:0]           mask_time_reg;       // Mask count
   logic [7:0]           mask_time_next;
   logic [7:0]           mode_reg;            // Mode bits
   logic [7:0]           mode_next;
   // Later stage values in force in gain control logic and the status match bit
   logic [7:0]           later_live_reg;
   logic [7:0]           later_live_next;

   // Write channel state
   logic                 bvalid_reg;
   logic [1:0]           bresp_reg;
   logic                 wr_take;             // Address and data taken together
   logic [ADDR_W-1:0]    wr_addr;
   logic                 wr_lane0;            // Byte lane 0 enabled
   logic                 wr_hit_first;
   logic                 wr_hit_later;
   logic                 wr_hit_mask;
   logic                 wr_hit_cmd;
   logic                 wr_hit_mode;
   logic                 wr_hit_stat;
   logic                 wr_mapped;
   logic                 set_default;         // Set-default command pulse
   logic                 gain_reset;          // Gain-reset command pulse

   // Read channel state
   logic                 rvalid_reg;
   logic [31:0]          rdata_reg;
   logic [1:0]           rresp_reg;
   logic                 rd_take;
   logic [ADDR_W-1:0]    rd_addr;
   logic                 rd_mapped;
   logic [7:0]           rd_byte;
   logic [7:0]           status_byte;

   // Registered decoded outputs
   rgm_pkg::rgm_first_s  am_first_reg;
   rgm_pkg::rgm_first_s  pm_first_reg;
   logic                 clip_reg;
   rgm_pkg::rgm_later_s  am_later_reg;
   rgm_pkg::rgm_later_s  pm_later_reg;

   // Mask timer outputs
   logic                 masked;
   logic                 squelch;

   // Write side decode; both channels are taken in one cycle, so order never matters
   assign wr_take      = S_AXI_AWVALID_I && S_AXI_WVALID_I && !bvalid_reg;
   assign wr_addr      = {S_AXI_AWADDR_I[ADDR_W-1:2], 2'b00};
   assign wr_lane0     = S_AXI_WSTRB_I[0];
   assign wr_hit_first = (wr_addr == ADDR_FIRST);
   assign wr_hit_later = (wr_addr == ADDR_LATER);
   assign wr_hit_mask  = (wr_addr == ADDR_MASK);
   assign wr_hit_cmd   = (wr_addr == ADDR_CMD);
   assign wr_hit_mode  = (wr_addr == ADDR_MODE);
   assign wr_hit_stat  = (wr_addr == ADDR_STAT);
   assign wr_mapped    = wr_hit_first || wr_hit_later || wr_hit_mask
                      || wr_hit_cmd || wr_hit_mode || wr_hit_stat;

   // Command pulses fire for one cycle on a write of one
   assign set_default = wr_take && wr_hit_cmd && wr_lane0 && S_AXI_WDATA_I[rgm_pkg::CMD_SET_DEFAULT];
   assign gain_reset  = wr_take && wr_hit_cmd && wr_lane0 && S_AXI_WDATA_I[rgm_pkg::CMD_GAIN_RESET];

   // Next values except mode: set-default beats an ordinary write in the same cycle
   assign first_gain_next = set_default ? rgm_pkg::RST_FIRST_GAIN
                          : (wr_take && wr_hit_first && wr_lane0) ? S_AXI_WDATA_I[7:0] : first_gain_reg;
   assign later_gain_next = set_default ? rgm_pkg::RST_LATER_GAIN
                          : (wr_take && wr_hit_later && wr_lane0) ? S_AXI_WDATA_I[7:0] : later_gain_reg;
   assign mask_time_next  = set_default ? rgm_pkg::RST_MASK_TIME
                          : (wr_take && wr_hit_mask && wr_lane0) ? S_AXI_WDATA_I[7:0] : mask_time_reg;
   assign mode_next       = (wr_take && wr_hit_mode && wr_lane0) ? S_AXI_WDATA_I[7:0] : mode_reg;
   // Later gain codes reach the gain logic only at gain reset or set-default; a write alone leaves them
   assign later_live_next = set_default ? rgm_pkg::RST_LATER_GAIN
                          : gain_reset ? later_gain_reg : later_live_reg;

   // Configuration registers
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         first_gain_reg <= rgm_pkg::RST_FIRST_GAIN;
         later_gain_reg <= rgm_pkg::RST_LATER_GAIN;
         mask_time_reg  <= rgm_pkg::RST_MASK_TIME;
         mode_reg       <= rgm_pkg::RST_MODE;
         later_live_reg <= rgm_pkg::RST_LATER_GAIN;
      end else begin
         first_gain_reg <= first_gain_next;
         later_gain_reg <= later_gain_next;
         mask_time_reg  <= mask_time_next;
         mode_reg       <= mode_next;
         later_live_reg <= later_live_next;
      end
   end

   // Write response; unmapped addresses answer with an error
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= rgm_pkg::RESP_OKAY;
      end else if (wr_take) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_mapped ? rgm_pkg::RESP_OKAY : rgm_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY_I) begin
         bvalid_reg <= 1'b0;
      end
   end

   assign S_AXI_AWREADY_O = wr_take;
   assign S_AXI_WREADY_O  = wr_take;
   assign S_AXI_BVALID_O  = bvalid_reg;
   assign S_AXI_BRESP_O   = bresp_reg;

   // Status shows block state: mask, squelch and whether the live later codes match the written ones
   assign status_byte = {2'b00, later_live_reg == later_gain_reg, 3'b000, squelch, masked};

   // Read side decode
   assign rd_take   = S_AXI_ARVALID_I && !rvalid_reg;
   assign rd_addr   = {S_AXI_ARADDR_I[ADDR_W-1:2], 2'b00};
   assign rd_mapped = (rd_addr == ADDR_FIRST) || (rd_addr == ADDR_LATER) || (rd_addr == ADDR_MASK)
                   || (rd_addr == ADDR_CMD) || (rd_addr == ADDR_MODE) || (rd_addr == ADDR_STAT);
   assign rd_byte   = (rd_addr == ADDR_FIRST) ? first_gain_reg
                    : (rd_addr == ADDR_LATER) ? later_gain_reg
                    : (rd_addr == ADDR_MASK)  ? mask_time_reg
                    : (rd_addr == ADDR_MODE)  ? mode_reg
                    : (rd_addr == ADDR_STAT)  ? status_byte
                    : 8'h00;   // Command register reads zero

   // Read data held until the master takes it
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= rgm_pkg::RESP_OKAY;
      end else if (rd_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= {24'h00_0000, rd_byte};
         rresp_reg  <= rd_mapped ? rgm_pkg::RESP_OKAY : rgm_pkg::RESP_SLVERR;
      end else if (S_AXI_RREADY_I) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign S_AXI_ARREADY_O = rd_take;
   assign S_AXI_RVALID_O  = rvalid_reg;
   assign S_AXI_RDATA_O   = rdata_reg;
   assign S_AXI_RRESP_O   = rresp_reg;

   // Decoded gains registered so the analog controls never glitch
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I) begin
         am_first_reg <= '0;
         pm_first_reg <= '0;
         clip_reg     <= 1'b0;
         am_later_reg <= '0;
         pm_later_reg <= '0;
      end else begin
         am_first_reg <= decode_first(first_gain_reg[rgm_pkg::F1_AM_LSB +: 3]);
         pm_first_reg <= decode_first(first_gain_reg[rgm_pkg::F1_PM_LSB +: 3]);
         clip_reg     <= first_gain_reg[rgm_pkg::F1_CLIP];
         // Preset acts at once; host restarts the receiver after clearing it
         am_later_reg <= decode_later(later_live_reg[rgm_pkg::F2_AM_LSB +: 4],
                                      first_gain_reg[rgm_pkg::F1_PRESET]);
         pm_later_reg <= decode_later(later_live_reg[rgm_pkg::F2_PM_LSB +: 4],
                                      first_gain_reg[rgm_pkg::F1_PRESET]);
      end
   end

   assign AM_FIRST_GAIN_O = am_first_reg;
   assign PM_FIRST_GAIN_O = pm_first_reg;
   assign CLIP_EN_O       = clip_reg;
   assign AM_LATER_GAIN_O = am_later_reg;
   assign PM_LATER_GAIN_O = pm_later_reg;

   // Mask receive timer
   rgm_mask_timer u_mask (
      .clk_i         (CLK_SYS_I),
      .rst_i         (SYS_RST_I),
      .fc_tick_i     (FC_TICK_I),
      .eot_i         (TX_END_I),
      .count_i       (mask_time_reg),
      .slow_i        (mode_reg[rgm_pkg::MODE_BITRATE_DET]),
      .typea_i       (mode_reg[rgm_pkg::MODE_TYPEA_106]),
      .dyn_squelch_i (mode_reg[rgm_pkg::MODE_DYN_SQUELCH]),
      .masked_o      (masked),
      .squelch_o     (squelch)
   );

   // Receiver output is dropped while masked
   assign RX_MASKED_O = masked;
   assign RX_OUT_O    = RX_OUT_I && !masked;
   assign SQUELCH_O   = squelch;
endmodule
`default_nettype wire

// ==== test/rgm_top_assertions.sv ====
// Assertion checker for the receive gain and mask timer block
`timescale 1ns/1ps
`default_nettype none
module rgm_top_chk (
   input wire logic       CLK_SYS_I,
   input wire logic       SYS_RST_I,
   input wire logic       S_AXI_AWVALID_I,
   input wire logic       S_AXI_AWREADY_O,
   input wire logic       FC_TICK_I,
   input wire logic       TX_END_I,
   input wire logic       RX_OUT_I,
   input wire logic [3:0] AM_FIRST_GAIN_O,
   input wire logic       CLIP_EN_O,
   input wire logic [5:0] AM_LATER_GAIN_O,
   input wire logic       RX_MASKED_O,
   input wire logic       RX_OUT_O,
   input wire logic       SQUELCH_O
);
   logic [16:0] ticks_reg;  // Carrier ticks masked since end of Tx
   wire         aw_take = S_AXI_AWVALID_I & S_AXI_AWREADY_O;
   // Wide enough for the slow step, so no wrap hides a short mask
   always_ff @(posedge CLK_SYS_I) begin
      if (SYS_RST_I || TX_END_I)
         ticks_reg <= 17'h0;
      else if (FC_TICK_I && RX_MASKED_O)
         ticks_reg <= ticks_reg + 17'h1;
   end
   default clocking @(posedge CLK_SYS_I);
   endclocking
   default disable iff (SYS_RST_I);
   property p_gate; RX_OUT_O == (RX_OUT_I && !RX_MASKED_O); endproperty
   a_gate: assert property (p_gate) else $error("output passes while masked");
   property p_restart; TX_END_I |=> RX_MASKED_O; endproperty
   a_restart: assert property (p_restart) else $error("no mask after end of Tx");
   property p_min; $fell(RX_MASKED_O) |-> ticks_reg >= 17'h100; endproperty
   a_min: assert property (p_min) else $error("mask under four steps");
   property p_sq; SQUELCH_O |-> RX_MASKED_O && ticks_reg >= 17'h100; endproperty
   a_sq: assert property (p_sq) else $error("squelch outside window");
   property p_first;
      !(AM_FIRST_GAIN_O[3] && AM_FIRST_GAIN_O[2:0] != 3'h0) && AM_FIRST_GAIN_O[2:0] != 3'h7;
   endproperty
   a_first: assert property (p_first) else $error("bad first stage code");
   property p_later; AM_LATER_GAIN_O[2:0] != 3'h0 |-> AM_LATER_GAIN_O[5:3] == 3'h4; endproperty
   a_later: assert property (p_later) else $error("cut before widest window");
   property p_load; !$stable(AM_LATER_GAIN_O) |-> $past(aw_take, 2); endproperty
   a_load: assert property (p_load) else $error("later gain moved alone");
   property p_clip; !$stable(CLIP_EN_O) |-> $past(aw_take) || $past(aw_take, 2); endproperty
   a_clip: assert property (p_clip) else $error("clip moved alone");
endmodule
bind rgm_top rgm_top_chk rgm_top_chk_inst (.*);
`default_nettype wire

// ==== test/rgm_host_model.sv ====
// Host model that programs the registers over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module rgm_host_model (
   input  wire logic        clk_i,
   output logic             awvalid_o,
   output logic             wvalid_o,
   output logic             bready_o,
   output logic [11:0]      awaddr_o,
   output logic [31:0]      wdata_o,
   input  wire logic        awready_i,
   input  wire logic        wready_i,
   input  wire logic        bvalid_i,
   input  wire logic [1:0]  bresp_i,
   output logic             arvalid_o,
   output logic             rready_o,
   output logic [11:0]      araddr_o,
   input  wire logic        arready_i,
   input  wire logic        rvalid_i,
   input  wire logic [31:0] rdata_i,
   input  wire logic [1:0]  rresp_i
);
   // Idle bus from time zero
   initial {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o, awaddr_o, wdata_o, araddr_o} = '0;
   // Address and data offered together; code 3 means no answer came
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      r = 2'h3;
      @(posedge clk_i);
      {awaddr_o, wdata_o} <= {a, d};
      {awvalid_o, wvalid_o, bready_o} <= 3'h7;
      for (int n = 0; n < 64 && r === 2'h3; n++) begin
         @(posedge clk_i);
         if (awready_i) awvalid_o <= 1'b0;
         if (wready_i) wvalid_o <= 1'b0;
         if (bvalid_i) r = bresp_i;
      end
      bready_o <= 1'b0;
   endtask
   // Single read, data taken at the edge that sees the answer
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      {d, r} = {32'h0, 2'h3};
      @(posedge clk_i);
      araddr_o <= a;
      {arvalid_o, rready_o} <= 2'h3;
      for (int n = 0; n < 64 && r === 2'h3; n++) begin
         @(posedge clk_i);
         if (arready_i) arvalid_o <= 1'b0;
         if (rvalid_i) {d, r} = {rdata_i, rresp_i};
      end
      rready_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the receive gain and mask timer block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic                clk, rst, fc, txe, rxi, clip, msk, rxo, sq;
   logic                awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
   logic [11:0]         awa, ara;
   logic [31:0]         wd, rdt, lfsr;
   logic [1:0]          bre, rre;
   rgm_pkg::rgm_first_s am1, pm1;
   rgm_pkg::rgm_later_s am2, pm2;
   int                  mismatches, samples_checked;
   rgm_top rgm_top_inst (.CLK_SYS_I(clk), .SYS_RST_I(rst), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
      .S_AXI_AWADDR_I(awa), .S_AXI_AWPROT_I(3'h0), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd),
      .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_BRESP_O(bre),
      .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_ARADDR_I(ara), .S_AXI_ARPROT_I(3'h0),
      .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .S_AXI_RDATA_O(rdt), .S_AXI_RRESP_O(rre), .FC_TICK_I(fc),
      .TX_END_I(txe), .RX_OUT_I(rxi), .AM_FIRST_GAIN_O(am1), .PM_FIRST_GAIN_O(pm1), .CLIP_EN_O(clip),
      .AM_LATER_GAIN_O(am2), .PM_LATER_GAIN_O(pm2), .RX_MASKED_O(msk), .RX_OUT_O(rxo), .SQUELCH_O(sq));
   rgm_host_model rgm_host_model_inst (.clk_i(clk), .awvalid_o(awv), .wvalid_o(wv), .bready_o(br),
      .awaddr_o(awa), .wdata_o(wd), .awready_i(awr), .wready_i(wrd), .bvalid_i(bv), .bresp_i(bre),
      .arvalid_o(arv), .rready_o(rr), .araddr_o(ara), .arready_i(arr), .rvalid_i(rv), .rdata_i(rdt),
      .rresp_i(rre));
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Reference decodes: boost or cut steps; window first, then cut
   function automatic logic [3:0] m_first(input int c);
      return (c == 7) ? 4'h8 : 4'(c);
   endfunction
   function automatic logic [5:0] m_later(input int c);
      return (c <= 4) ? {3'(c), 3'h0} : {3'h4, 3'(c - 4)};
   endfunction
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Carrier tick every second cycle, random receiver output
   always @(posedge clk) begin
      fc <= ~fc;
      lfsr <= lfsr_next(lfsr);
      rxi <= lfsr[0];
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Register access by index; a lost answer ends the run
   task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
      logic [1:0] r;
      rgm_host_model_inst.wr({2'h0, idx, 2'h0}, {24'h0, d}, r);
      chk("write resp", rgm_pkg::RESP_OKAY, r);
      if (r === 2'h3) wrap_up;
   endtask
   task automatic rreg(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er = rgm_pkg::RESP_OKAY);
      logic [31:0] d;
      logic [1:0]  r;
      rgm_host_model_inst.rd({2'h0, idx, 2'h0}, d, r);
      chk("read data", {24'h0, e}, d);
      chk("read resp", er, r);
      if (r === 2'h3) wrap_up;
   endtask
   // End of Tx, count masked ticks and ticks before squelch; optional second end of Tx
   task automatic mask_run(input logic [7:0] cnt, input logic [7:0] mode, input int step, input bit again);
      int ticks, quiet;
      wreg(rgm_pkg::IDX_MODE, mode);
      wreg(rgm_pkg::IDX_MASK_TIME, cnt);
      for (int n = 0; n < 40000 && (n < 2 || msk === 1'b1); n++) begin
         @(posedge clk);
         txe <= (n == 0 || (again && n == 300));
         @(negedge clk);
         chk("rx out", rxi & ~msk, rxo);
         if (txe) {ticks, quiet} = '0;
         else if (fc === 1'b1 && msk === 1'b1) begin
            ticks++;
            quiet += (sq !== 1'b1);
         end
      end
      chk("mask ticks", (cnt < 4 ? 4 : cnt) * step, ticks);
      chk("squelch start", mode[2] ? 256 : ticks, quiet);
   endtask
   initial begin
      rst = 1'b1;
      {fc, txe, rxi} = 3'h0;
      lfsr = 32'h81332def;
      {mismatches, samples_checked} = '0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rreg(rgm_pkg::IDX_FIRST_GAIN, rgm_pkg::RST_FIRST_GAIN);
      rreg(rgm_pkg::IDX_LATER_GAIN, rgm_pkg::RST_LATER_GAIN);
      rreg(rgm_pkg::IDX_COMMAND, 8'h00);
      rreg(8'h40, 8'h00, rgm_pkg::RESP_SLVERR);
      for (int c = 0; c < 8; c++) begin
         wreg(rgm_pkg::IDX_FIRST_GAIN, {c[2:0], 3'(7 - c), c[0], 1'b0});
         @(negedge clk);
         chk("am first", m_first(c), am1);
         chk("pm first", m_first(7 - c), pm1);
         chk("clip", c[0], clip);
      end
      for (int c = 0; c <= 10; c++) begin
         wreg(rgm_pkg::IDX_LATER_GAIN, {c[3:0], 4'(10 - c)});
         @(negedge clk);
         chk("later held", m_later(c > 0 ? c - 1 : 0), am2);
         wreg(rgm_pkg::IDX_COMMAND, 8'h02);
         @(negedge clk);
         chk("am later", m_later(c), am2);
         chk("pm later", m_later(10 - c), pm2);
      end
      rreg(rgm_pkg::IDX_STATUS, 8'h20);
      wreg(rgm_pkg::IDX_FIRST_GAIN, 8'h01);
      @(negedge clk);
      chk("preset am", 6'h22, am2);
      chk("preset pm", 6'h22, pm2);
      wreg(rgm_pkg::IDX_FIRST_GAIN, 8'h00);
      wreg(rgm_pkg::IDX_COMMAND, 8'h02);
      @(negedge clk);
      chk("after preset", m_later(10), am2);
      wreg(rgm_pkg::IDX_MASK_TIME, 8'h33);
      wreg(rgm_pkg::IDX_COMMAND, 8'h01);
      rreg(rgm_pkg::IDX_MASK_TIME, rgm_pkg::RST_MASK_TIME);
      rreg(rgm_pkg::IDX_FIRST_GAIN, rgm_pkg::RST_FIRST_GAIN);
      chk("live later", 0, am2);
      mask_run(8'h00, 8'h04, 64, 1'b0);
      mask_run(8'h04, 8'h04, 64, 1'b1);
      mask_run(8'hff, 8'h00, 64, 1'b0);
      mask_run(8'h05, 8'h05, 512, 1'b0);
      mask_run(8'h06, 8'h02, 64, 1'b0);
      mask_run({1'b0, lfsr[6:0]}, 8'h04, 64, 1'b0);
      wrap_up;
   end
   // Cut a hang short
   initial begin
      repeat (99000) @(posedge clk);
      mismatches++;
      wrap_up;
   end
endmodule
`default_nettype wire
